//--- sibcr_pkg.sv
// Purpose: Shared constants and types for the multi-bank command tracker
// Assumes: One 10 MHz clock shared with the memory controller
// Notes:   Cycle counts round least times up to whole clocks
package sibcr_pkg;
   localparam int CLK_PERIOD_NS               = 100;
   localparam int PRECHARGE_TIME_NS           = 18;
   localparam int ACTIVATE_TO_COLUMN_DELAY_NS = 18;
   localparam int WRITE_RECOVERY_NS           = 15;
   localparam int SELF_REFRESH_EXIT_TIME_NS   = 120;

   localparam logic [2:0] PRE_CYC = 3'((PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [2:0] RCD_CYC =
      3'((ACTIVATE_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [2:0] WR_CYC  = 3'((WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [2:0] XSR_CYC =
      3'((SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   localparam int         CAS_LATENCY = 2;
   localparam logic [2:0] BURST_LEN   = 3'h4;
   localparam int         NUM_BANKS   = 4;
   localparam int         BANK_W      = 2;
   localparam int         COL_W       = 4;
   localparam int         ADDR_W      = 12;
   localparam int         AP_BIT      = 10;
   localparam int         DATA_W      = 32;
   localparam int         MASK_W      = 4;
   localparam int         FIFO_DEPTH  = 8;
   localparam int         MEM_AW      = BANK_W + COL_W;

   typedef enum logic [3:0] {
      CMD_INHIBIT,
      CMD_NOP,
      CMD_ACTIVE,
      CMD_READ,
      CMD_WRITE,
      CMD_PRECHARGE,
      CMD_BURST_STOP,
      CMD_REFRESH,
      CMD_LOAD_MODE
   } sibcr_cmd_type;

   typedef enum logic [3:0] {
      BANK_IDLE,
      BANK_ACTIVATING,
      BANK_ACTIVE,
      BANK_READ,
      BANK_WRITE,
      BANK_READ_AP,
      BANK_WRITE_AP,
      BANK_AP_RECOVER,
      BANK_AP_PRECHARGE,
      BANK_PRECHARGING
   } sibcr_bank_state_type;
endpackage

//--- sibcr_core.sv
// Purpose: Device-side bank state tracking and burst data path across banks
// Assumes: Controller shares clock_i; row address is not stored (column array only)
// Notes:   Write data is buffered; a read right after a write may see older data
// How it works
// [RULE1] Commands act only with clock enable high now and before, after refresh exit.
// [RULE2] Chip select low plus row, column and write strobes decode the command.
// [RULE3] Commands to another bank are accepted while one bank is in auto precharge.
// [RULE4] Controller keeps each command legal for the target bank's own state.
// [RULE5] Refresh, self refresh and mode load only issued with all banks idle.
// [RULE6] Burst stop always hits the bank whose burst is running.
// [RULE7] Interrupted auto precharge burst starts its own precharge.
// [RULE8] Precharge to another bank leaves the running burst untouched.
// [RULE9] Interrupting read data takes over one CAS latency after its command.
// [RULE10] Write cuts a read at once; controller masks data two clocks before.
// [RULE11] Read cuts a write; last write datum is the clock before the read.
// [RULE12] Write cuts a write; last datum is the one before the new write.
// [RULE13] Interrupted read with auto precharge precharges from the interrupting command.
// [RULE14] Auto precharge banks go idle once precharge time follows internal precharge.
// [RULE15] Idle after precharge time; active after activate delay with no burst.
// [RULE16] Controller never drives unlisted states or command sequences.
// [RULE17] Chip select high is ignored; all strobes high is no operation.
// [RULE18] Interrupted write with auto precharge waits write recovery before precharging.
`timescale 1ns/1ns

module sibcr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clock_i,
   input  wire logic             srst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] store_reg [DEPTH];
   logic [PW-1:0]    wp_reg;
   logic [PW-1:0]    rp_reg;
   logic [PW:0]      count_reg;
   wire              push = in_valid_i && in_ready_o;
   wire              pop  = out_valid_o && out_ready_i;

   assign in_ready_o  = count_reg != (PW+1)'(DEPTH);
   assign out_valid_o = count_reg != '0;
   assign out_data_o  = store_reg[rp_reg];

   always_ff @(posedge clock_i) begin
      if (push) begin
         store_reg[wp_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         wp_reg    <= '0;
         rp_reg    <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= (wp_reg == PW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
         end
         if (pop) begin
            rp_reg <= (rp_reg == PW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
         end
         count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule // sibcr_fifo

module sibcr_core (
   input  wire logic                           clock_i,
   input  wire logic                           srst_i,
   input  wire logic                           cke_i,
   input  wire logic                           cs_n_i,
   input  wire logic                           ras_n_i,
   input  wire logic                           cas_n_i,
   input  wire logic                           we_n_i,
   input  wire logic [sibcr_pkg::BANK_W-1:0]   ba_i,
   input  wire logic [sibcr_pkg::ADDR_W-1:0]   addr_i,
   input  wire logic [sibcr_pkg::MASK_W-1:0]   dqm_i,
   input  wire logic [sibcr_pkg::DATA_W-1:0]   dq_i,
   output logic      [sibcr_pkg::DATA_W-1:0]   dq_o,
   output logic                                dq_oe_o,
   output logic      [sibcr_pkg::NUM_BANKS-1:0] bank_idle_o,
   output logic                                wr_ready_o
);
   import sibcr_pkg::*;

   localparam int FW = MEM_AW + MASK_W + DATA_W;

   logic                 cke_prev_reg;
   logic                 self_ref_reg;
   logic [2:0]           xsr_reg;
   logic                 burst_active_reg;
   logic                 burst_write_reg;
   logic [BANK_W-1:0]    burst_bank_reg;
   logic [COL_W-1:0]     burst_col_reg;
   logic [2:0]           burst_left_reg;
   logic [MEM_AW-1:0]    pipe_addr_reg [CAS_LATENCY-1];
   logic                 pipe_vld_reg  [CAS_LATENCY-1];
   logic [DATA_W-1:0]    mem_reg [2**MEM_AW];
   logic [NUM_BANKS-1:0] col_ok;
   logic [NUM_BANKS-1:0] ap_busy;
   logic [NUM_BANKS-1:0] idle_vec;
   logic                 fifo_in_ready;
   logic                 fifo_out_valid;
   logic [FW-1:0]        fifo_out_data;

   // [RULE1] clock enable and exit gating
   wire cmd_en = cke_prev_reg && cke_i && !self_ref_reg && (xsr_reg == 3'h0);

   // [RULE2] strobe decode
   // [RULE17] inhibit and no operation
   wire [2:0] strobes = {ras_n_i, cas_n_i, we_n_i};
   sibcr_cmd_type raw_cmd;
   assign raw_cmd = cs_n_i             ? CMD_INHIBIT    :
                    (strobes == 3'h7) ? CMD_NOP        :
                    (strobes == 3'h3) ? CMD_ACTIVE     :
                    (strobes == 3'h5) ? CMD_READ       :
                    (strobes == 3'h4) ? CMD_WRITE      :
                    (strobes == 3'h2) ? CMD_PRECHARGE  :
                    (strobes == 3'h6) ? CMD_BURST_STOP :
                    (strobes == 3'h1) ? CMD_REFRESH    :
                    (strobes == 3'h0) ? CMD_LOAD_MODE  : CMD_NOP;
   sibcr_cmd_type cmd;
   assign cmd = cmd_en ? raw_cmd : CMD_NOP;

   wire              ap_flag  = addr_i[AP_BIT];
   wire [COL_W-1:0]  cmd_col  = addr_i[COL_W-1:0];
   wire              is_act   = cmd == CMD_ACTIVE;
   wire              is_pre   = cmd == CMD_PRECHARGE;
   wire              is_bst   = (cmd == CMD_BURST_STOP) && burst_active_reg;
   wire              all_idle = &idle_vec;

   // [RULE3] other bank busy does not block
   // [RULE4] target bank state decides
   wire new_burst = ((cmd == CMD_READ) || (cmd == CMD_WRITE)) && col_ok[ba_i];
   wire new_write = new_burst && (cmd == CMD_WRITE);
   wire other_bank = ba_i != burst_bank_reg;

   // [RULE8] precharge elsewhere keeps burst
   wire pre_kill = is_pre && burst_active_reg && (ap_flag || !other_bank)
                   && !ap_busy[burst_bank_reg];

   // [RULE6] stop hits the running burst
   // [RULE7] interruption ends old bank burst
   wire burst_end = burst_active_reg &&
                    ((new_burst && other_bank) || is_bst ||
                     (!new_burst && (burst_left_reg == 3'h1)));

   // [RULE9] newest burst owns the issue slot
   wire              issue_vld   = new_burst || (burst_active_reg && !is_bst && !pre_kill);
   wire              issue_write = new_burst ? new_write : burst_write_reg;
   wire [MEM_AW-1:0] issue_addr  = new_burst ? {ba_i, cmd_col} : {burst_bank_reg, burst_col_reg};
   wire              rd_issue    = issue_vld && !issue_write;
   // [RULE11] read cycle takes no write datum
   // [RULE12] new write supplies the next datum
   wire              wr_issue    = issue_vld && issue_write;

   genvar b;
   generate
      for (b = 0; b < NUM_BANKS; b++) begin : g_bank
         sibcr_bank_state_type st_reg;
         sibcr_bank_state_type st_next;
         logic [2:0]           tmr_reg;
         logic [2:0]           tmr_next;
         wire hit       = ba_i == BANK_W'(b);
         wire tmr_done  = tmr_reg == 3'h0;
         wire pre_hit   = is_pre && (ap_flag || hit);
         wire col_hit   = new_burst && hit;
         wire end_here  = burst_end && (burst_bank_reg == BANK_W'(b));
         sibcr_bank_state_type col_state;
         assign col_state = new_write ? (ap_flag ? BANK_WRITE_AP : BANK_WRITE)
                                      : (ap_flag ? BANK_READ_AP : BANK_READ);

         assign col_ok[b]   = (st_reg == BANK_ACTIVE) || (st_reg == BANK_READ) ||
                              (st_reg == BANK_WRITE);
         assign ap_busy[b]  = (st_reg == BANK_READ_AP) || (st_reg == BANK_WRITE_AP);
         assign idle_vec[b] = st_reg == BANK_IDLE;

         always_comb begin
            st_next  = st_reg;
            tmr_next = tmr_done ? 3'h0 : tmr_reg - 3'h1;
            unique case (st_reg)
               BANK_IDLE: begin
                  if (is_act && hit) begin
                     st_next  = BANK_ACTIVATING;
                     tmr_next = RCD_CYC - 3'h1;
                  end
               end
               // [RULE15] activate delay then row active
               BANK_ACTIVATING: begin
                  if (tmr_done) begin
                     st_next = BANK_ACTIVE;
                  end
               end
               BANK_ACTIVE, BANK_READ, BANK_WRITE: begin
                  if (col_hit) begin
                     st_next = col_state;
                  end else if (pre_hit) begin
                     st_next  = BANK_PRECHARGING;
                     tmr_next = PRE_CYC - 3'h1;
                  end else if (end_here) begin
                     st_next = BANK_ACTIVE;
                  end
               end
               // [RULE13] precharge from interrupting command
               BANK_READ_AP: begin
                  if (end_here) begin
                     st_next  = BANK_AP_PRECHARGE;
                     tmr_next = PRE_CYC - 3'h1;
                  end
               end
               // [RULE18] write recovery before precharge
               BANK_WRITE_AP: begin
                  if (end_here) begin
                     st_next  = BANK_AP_RECOVER;
                     tmr_next = WR_CYC - 3'h1;
                  end
               end
               BANK_AP_RECOVER: begin
                  if (tmr_done) begin
                     st_next  = BANK_AP_PRECHARGE;
                     tmr_next = PRE_CYC - 3'h1;
                  end
               end
               // [RULE14] auto precharge ends idle
               // [RULE15] precharge time then idle
               BANK_AP_PRECHARGE, BANK_PRECHARGING: begin
                  if (tmr_done) begin
                     st_next = BANK_IDLE;
                  end
               end
            endcase
         end

         always_ff @(posedge clock_i) begin
            if (srst_i) begin
               st_reg  <= BANK_IDLE;
               tmr_reg <= 3'h0;
            end else begin
               st_reg  <= st_next;
               tmr_reg <= tmr_next;
            end
         end
      end
   endgenerate

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cke_prev_reg <= 1'b0;
         self_ref_reg <= 1'b0;
         xsr_reg      <= 3'h0;
      end else begin
         cke_prev_reg <= cke_i;
         if (self_ref_reg && cke_i) begin
            self_ref_reg <= 1'b0;
            xsr_reg      <= XSR_CYC;
         // [RULE5] refresh entry only with all idle
         end else if (!cs_n_i && (strobes == 3'h1) && cke_prev_reg && !cke_i && all_idle) begin
            self_ref_reg <= 1'b1;
         end else if (xsr_reg != 3'h0) begin
            xsr_reg <= xsr_reg - 3'h1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         burst_active_reg <= 1'b0;
         burst_write_reg  <= 1'b0;
         burst_bank_reg   <= '0;
         burst_col_reg    <= '0;
         burst_left_reg   <= 3'h0;
      end else if (new_burst) begin
         burst_active_reg <= BURST_LEN != 3'h1;
         burst_write_reg  <= new_write;
         burst_bank_reg   <= ba_i;
         burst_col_reg    <= cmd_col + COL_W'(1);
         burst_left_reg   <= BURST_LEN - 3'h1;
      end else if (burst_active_reg) begin
         burst_active_reg <= !(is_bst || pre_kill || (burst_left_reg == 3'h1));
         burst_col_reg    <= burst_col_reg + COL_W'(1);
         burst_left_reg   <= burst_left_reg - 3'h1;
      end
   end

   // Read path: CAS_LATENCY-1 address stages plus the output flop
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         for (int i = 0; i < CAS_LATENCY - 1; i++) begin
            pipe_vld_reg[i]  <= 1'b0;
            pipe_addr_reg[i] <= '0;
         end
         dq_o    <= '0;
         dq_oe_o <= 1'b0;
      end else begin
         pipe_vld_reg[0]  <= rd_issue;
         pipe_addr_reg[0] <= issue_addr;
         for (int i = 1; i < CAS_LATENCY - 1; i++) begin
            pipe_vld_reg[i]  <= pipe_vld_reg[i-1] && !new_write;
            pipe_addr_reg[i] <= pipe_addr_reg[i-1];
         end
         dq_o <= mem_reg[pipe_addr_reg[CAS_LATENCY-2]];
         // [RULE10] write cuts read data at once
         dq_oe_o <= pipe_vld_reg[CAS_LATENCY-2] && !new_write;
      end
   end

   // Reads own the array port; pending writes wait, so the buffer can fill
   wire drain = fifo_out_valid && !rd_issue;

   sibcr_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_wfifo (
      .clock_i     (clock_i),
      .srst_i      (srst_i),
      .in_valid_i  (wr_issue),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   ({issue_addr, dqm_i, dq_i}),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (!rd_issue),
      .out_data_o  (fifo_out_data)
   );

   wire [MEM_AW-1:0] dr_addr = fifo_out_data[FW-1 -: MEM_AW];
   wire [MASK_W-1:0] dr_mask = fifo_out_data[DATA_W +: MASK_W];
   wire [DATA_W-1:0] dr_data = fifo_out_data[DATA_W-1:0];

   always_ff @(posedge clock_i) begin
      if (drain) begin
         for (int k = 0; k < MASK_W; k++) begin
            if (!dr_mask[k]) begin
               mem_reg[dr_addr][k*8 +: 8] <= dr_data[k*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         bank_idle_o <= '1;
         wr_ready_o  <= 1'b1;
      end else begin
         bank_idle_o <= idle_vec;
         wr_ready_o  <= fifo_in_ready;
      end
   end
endmodule // sibcr_core

//--- sibcr_top_note_unused.sv
// Purpose: Spare slot, holds no logic
// Assumes: Nothing
// Notes:   All logic of the block lives in the core file

//--- sibcr_core_assertions.sv
// Purpose: Port checks for the multi-bank command tracker
// Assumes: One clock, sync reset, no command inside the self refresh exit wait
// Notes:   Decode mirrors the strobe encoding; bank index kept two deep
`timescale 1ns/1ns
module sibcr_core_checker
   import sibcr_pkg::*;
(
   input wire logic                          clock_i,
   input wire logic                          srst_i,
   input wire logic                          cke_i,
   input wire logic                          cs_n_i,
   input wire logic                          ras_n_i,
   input wire logic                          cas_n_i,
   input wire logic                          we_n_i,
   input wire logic [sibcr_pkg::BANK_W-1:0]    ba_i,
   input wire logic [sibcr_pkg::ADDR_W-1:0]    addr_i,
   input wire logic                          dq_oe_o,
   input wire logic [sibcr_pkg::NUM_BANKS-1:0] bank_idle_o
);
   logic              cke_prev_reg;
   logic [BANK_W-1:0] ba1_reg;
   logic [BANK_W-1:0] ba2_reg;
   wire go     = cke_i && cke_prev_reg && !cs_n_i;
   wire cmd_go = go && !(ras_n_i && cas_n_i && we_n_i);
   wire rd_go  = go && ras_n_i && !cas_n_i && we_n_i;
   wire wr_go  = go && ras_n_i && !cas_n_i && !we_n_i;
   wire act_go = go && !ras_n_i && cas_n_i && we_n_i;
   always_ff @(posedge clock_i) begin
      cke_prev_reg <= srst_i ? 1'b0 : cke_i;
      ba1_reg <= ba_i;
      ba2_reg <= ba1_reg;
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   a_read_latency: assert property (rd_go && !bank_idle_o[ba_i] ##1 !wr_go |=> dq_oe_o)
      else $error("read data late");
   a_oe_cause: assert property ($rose(dq_oe_o) |-> $past(rd_go, 2))
      else $error("read data without read");
   a_write_cut: assert property (wr_go |=> !dq_oe_o)
      else $error("write did not cut read");
   a_nop_hold: assert property (!cmd_go ##1 (!cmd_go && bank_idle_o == 4'hf) |=>
      bank_idle_o == 4'hf) else $error("idle lost on no command");
   a_act_busy: assert property (act_go |-> ##2 !bank_idle_o[ba2_reg])
      else $error("activated bank still idle");
   a_rd_ap_idle: assert property (rd_go && addr_i[AP_BIT] && ba_i == 2'h0 |->
      ##[2:12] bank_idle_o[0]) else $error("read auto precharge stuck");
   a_cut_prech: assert property (rd_go && addr_i[AP_BIT] && ba_i == 2'h0
      ##1 ((rd_go || wr_go) && ba_i != 2'h0) |-> ##[1:4] bank_idle_o[0])
      else $error("cut read precharge late");
   a_wr_ap_hold: assert property (wr_go && addr_i[AP_BIT] && ba_i == 2'h1 |=>
      !bank_idle_o[1] [*3] ##[1:12] bank_idle_o[1])
      else $error("write auto precharge timing");
   c_rd_rd: cover property (rd_go ##2 rd_go);
   c_rd_wr: cover property (rd_go ##1 wr_go);
   c_wr_ap: cover property (wr_go && addr_i[AP_BIT]);
endmodule // sibcr_core_checker

bind sibcr_core sibcr_core_checker i_chk (
   .clock_i(clock_i), .srst_i(srst_i), .cke_i(cke_i), .cs_n_i(cs_n_i),
   .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .ba_i(ba_i),
   .addr_i(addr_i), .dq_oe_o(dq_oe_o), .bank_idle_o(bank_idle_o)
);

//--- sibcr_ctrl_model.sv
// Purpose: Memory controller model driving commands one cycle per step
// Assumes: Caller sequences bank states legally
// Notes:   Released data bus shows the inverse of its value on the previous step
`timescale 1ns/1ns
module sibcr_ctrl_model
   import sibcr_pkg::*;
(
   input  wire logic                     clock_i,
   output logic                          cke_o,
   output logic                          cs_n_o,
   output logic                          ras_n_o,
   output logic                          cas_n_o,
   output logic                          we_n_o,
   output logic [sibcr_pkg::BANK_W-1:0]  ba_o,
   output logic [sibcr_pkg::ADDR_W-1:0]  addr_o,
   output logic [sibcr_pkg::MASK_W-1:0]  dqm_o,
   output logic [sibcr_pkg::DATA_W-1:0]  dq_o
);
   initial begin
      cke_o = 1'b0;
      cs_n_o = 1'b1;
      {ras_n_o, cas_n_o, we_n_o} = 3'h7;
      ba_o = '0;
      addr_o = '0;
      dqm_o = 4'hf;
      dq_o = '0;
   end
   task automatic step(input sibcr_cmd_type c, input logic [BANK_W-1:0] b,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [MASK_W-1:0] m, input logic dv, input logic ck);
      logic [2:0] code;
      case (c)
         CMD_ACTIVE:     code = 3'h3;
         CMD_READ:       code = 3'h5;
         CMD_WRITE:      code = 3'h4;
         CMD_PRECHARGE:  code = 3'h2;
         CMD_BURST_STOP: code = 3'h6;
         CMD_REFRESH:    code = 3'h1;
         CMD_LOAD_MODE:  code = 3'h0;
         default:        code = 3'h7;
      endcase
      @(posedge clock_i);
      #1;
      cke_o = ck;
      cs_n_o = (c == CMD_INHIBIT);
      {ras_n_o, cas_n_o, we_n_o} = code;
      ba_o = b;
      addr_o = a;
      dqm_o = m;
      dq_o = dv ? d : ~dq_o;
   endtask
endmodule // sibcr_ctrl_model

//--- sibcr_interbank_command_rules_tb.sv
// Purpose: Self-checking bench for cross-bank burst interruption
// Assumes: Write buffer drains within 12 idle cycles
// Notes:   Expected read words queued by the driver, popped by a monitor
`timescale 1ns/1ns
module sibcr_interbank_command_rules_tb;
   import sibcr_pkg::*;
   logic clock_i = 1'b0;
   logic srst_i = 1'b1;
   logic cke, cs_n, ras_n, cas_n, we_n, dq_oe_o, wr_ready_o;
   logic [BANK_W-1:0] ba;
   logic [ADDR_W-1:0] addr;
   logic [MASK_W-1:0] dqm;
   logic [DATA_W-1:0] dq, dq_o;
   logic [NUM_BANKS-1:0] bank_idle_o;
   logic [DATA_W-1:0] mem_q [64];
   logic [DATA_W-1:0] exp_q [$];
   int n_mismatch = 0;
   int check_count = 0;
   int cyc = 0;
   logic cke_v = 1'b1;
   always #50 clock_i = ~clock_i;
   sibcr_ctrl_model i_ctrl (.clock_i(clock_i), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
      .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr), .dqm_o(dqm), .dq_o(dq));
   sibcr_core i_dut (.clock_i(clock_i), .srst_i(srst_i), .cke_i(cke), .cs_n_i(cs_n),
      .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .addr_i(addr),
      .dqm_i(dqm), .dq_i(dq), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .bank_idle_o(bank_idle_o),
      .wr_ready_o(wr_ready_o));
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic nop(input int n);
      repeat (n) i_ctrl.step(CMD_NOP, 2'h0, 12'h000, 32'h0, 4'hf, 1'b0, cke_v);
   endtask
   task automatic cmd(input sibcr_cmd_type c, input logic [1:0] b, input logic [11:0] a);
      i_ctrl.step(c, b, a, 32'h0, 4'hf, 1'b0, 1'b1);
   endtask
   task automatic wr(input logic [1:0] b, input logic [3:0] col, input logic ap, input int n,
                     input logic rm);
      logic [DATA_W-1:0] d;
      logic [MASK_W-1:0] m;
      logic [5:0] ix;
      for (int i = 0; i < n; i++) begin
         d = $urandom;
         m = rm ? MASK_W'($urandom) : 4'h0;
         ix = {b, col + 4'(i)};
         for (int k = 0; k < MASK_W; k++)
            if (!m[k]) mem_q[ix][8*k +: 8] = d[8*k +: 8];
         i_ctrl.step(i == 0 ? CMD_WRITE : CMD_NOP, b, {1'b0, ap, 6'h0, col}, d, m, 1'b1, 1'b1);
      end
   endtask
   // Mask held high ahead of any cutting write
   task automatic rd(input logic [1:0] b, input logic [3:0] col, input logic ap, input int n,
                     input int nq);
      for (int i = 0; i < nq; i++)
         exp_q.push_back(mem_q[{b, col + 4'(i)}]);
      for (int i = 0; i < n; i++)
         i_ctrl.step(i == 0 ? CMD_READ : CMD_NOP, b, {1'b0, ap, 6'h0, col}, 32'h0, 4'hf,
                     1'b0, 1'b1);
   endtask
   task automatic act(input logic [1:0] b);
      cmd(CMD_ACTIVE, b, 12'h000);
      nop(2);
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   always @(posedge clock_i) begin
      if (!srst_i && dq_oe_o === 1'b1) begin
         if (exp_q.size() == 0)
            check({31'h0, dq_oe_o}, 32'h0);
         else
            check(dq_o, exp_q.pop_front());
      end
   end
   // Ceiling well above the roughly 370 cycles of stimulus
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         final_report();
      end
   end
   initial begin
      void'($urandom(26566));
      repeat (8) @(posedge clock_i);
      #1;
      check({28'h0, bank_idle_o}, 32'hf);
      check({30'h0, wr_ready_o, dq_oe_o}, 32'h2);
      srst_i = 1'b0;
      nop(2);
      for (int b = 0; b < 4; b++)
         act(2'(b));
      check({28'h0, bank_idle_o}, 32'h0);
      for (int b = 0; b < 4; b++)
         for (int c = 0; c < 12; c += 4) begin
            wr(2'(b), 4'(c), 1'b0, 4, 1'b0);
            nop(3);
         end
      nop(12);
      for (int b = 0; b < 4; b++)
         for (int c = 0; c < 12; c += 4) begin
            rd(2'(b), 4'(c), 1'b0, 4, 4);
            nop(2);
         end
      done("fill");
      rd(0, 0, 1'b0, 2, 2);
      rd(1, 0, 1'b0, 4, 4);
      nop(4);
      done("read_read");
      rd(0, 4, 1'b0, 1, 0);
      wr(1, 4, 1'b0, 4, 1'b1);
      nop(12);
      rd(1, 4, 1'b0, 4, 4);
      nop(4);
      done("read_write");
      wr(2, 4, 1'b0, 2, 1'b1);
      wr(3, 4, 1'b0, 4, 1'b1);
      nop(12);
      rd(2, 4, 1'b0, 4, 4);
      rd(3, 4, 1'b0, 4, 4);
      nop(4);
      done("write_write");
      wr(2, 0, 1'b0, 3, 1'b1);
      rd(3, 0, 1'b0, 4, 4);
      nop(12);
      rd(2, 0, 1'b0, 4, 4);
      nop(4);
      done("write_read");
      rd(0, 8, 1'b0, 1, 4);
      cmd(CMD_PRECHARGE, 1, 12'h000);
      nop(8);
      check({31'h0, bank_idle_o[1]}, 32'h1);
      act(1);
      done("precharge_other");
      cke_v = 1'b0;
      nop(1);
      cke_v = 1'b1;
      rd(0, 0, 1'b0, 4, 0);
      nop(6);
      done("clock_enable");
      rd(0, 0, 1'b1, 1, 1);
      rd(1, 0, 1'b0, 4, 4);
      nop(6);
      check({31'h0, bank_idle_o[0]}, 32'h1);
      done("read_ap_cut");
      wr(1, 8, 1'b1, 2, 1'b1);
      rd(2, 0, 1'b0, 4, 4);
      nop(12);
      check({30'h0, bank_idle_o[1:0]}, 32'h3);
      act(0);
      act(1);
      rd(1, 8, 1'b0, 4, 4);
      nop(4);
      done("write_ap_cut");
      rd(0, 4, 1'b0, 1, 1);
      cmd(CMD_BURST_STOP, 2, 12'h000);
      nop(4);
      done("burst_stop");
      cmd(CMD_PRECHARGE, 0, 12'h400);
      nop(4);
      check({28'h0, bank_idle_o}, 32'hf);
      cmd(CMD_REFRESH, 0, 12'h000);
      nop(4);
      check({28'h0, bank_idle_o}, 32'hf);
      check(32'(exp_q.size()), 32'h0);
      done("all_idle");
      i_ctrl.step(CMD_REFRESH, 2'h0, 12'h000, 32'h0, 4'hf, 1'b0, 1'b0);
      nop(3);
      act(0);
      check({28'h0, bank_idle_o}, 32'he);
      done("self_refresh");
      final_report();
   end
endmodule // sibcr_interbank_command_rules_tb
